// ===== serial_peer.sv
// remote serial transceiver facing the serial port's pins.
// assumes the bench sets bit_len, in clocks, before each frame.
`timescale 1ns/1ps
module serial_peer (
	input  wire logic clock,
	input  wire logic line_in,
	output logic      line_out
);
	int         bit_len = 64; // clocks per bit
	int         seen    = 0;  // frames captured so far
	logic [9:0] got;          // samples after the start bit
	initial line_out = 1'b1;  // pulled-up line idles high
	// start low, n bits lsb first, chosen stop level, then one idle bit
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		line_out <= 1'b0;
		repeat (bit_len) @(posedge clock);
		for (int i = 0; i < n; i++) begin
			line_out <= d[i];
			repeat (bit_len) @(posedge clock);
		end
		line_out <= stop; // a low stop only where a scenario asks
		repeat (bit_len) @(posedge clock);
		line_out <= 1'b1;
		repeat (bit_len) @(posedge clock);
	endtask
	// capture ten bit centres after a start; short frames end in idle
	always begin
		@(negedge line_in);
		repeat (bit_len / 2) @(posedge clock);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 10; i++) begin
				repeat (bit_len) @(posedge clock);
				got[i] = line_in;
			end
			seen++;
		end
	end
endmodule // serial_peer

// ===== serial_port.sv
// serial port with four frame modes, multiprocessor filter, baud doubler
// and one-wire mode, behind an avalon-mm slave with waitrequest.
// assumes timer 1 and timer 2 live outside and hand in one-cycle
// overflow pulses on the system clock; pins are synchronous inputs.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps

module serial_port (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic        timer1_overflow,
	input  wire logic        timer2_overflow,
	input  wire logic        rxd_in,
	output logic             rxd_out,
	output logic             rxd_oe,
	input  wire logic        txd_in,
	output logic             txd_out,
	output logic             txd_oe,
	output logic             irq
);
	import uart_pkg::*;

	logic        ack_q;          // second cycle of a bus access
	logic        wr_en;          // write takes effect this edge
	logic [7:0]  power_q;        // power_and_baud_control
	logic [7:0]  option_q;       // option_settings
	logic [7:0]  control_q;      // serial_control
	logic [1:0]  src_q;          // baud source selects
	logic [1:0]  irq_status_q;   // sticky events
	logic [1:0]  irq_enable_q;   // event enables
	logic [7:0]  rd_mux;         // read data before the flop
	logic [31:0] readdata_q;     // read data flop

	logic [1:0]  mode;           // frame mode
	logic        nine;           // nine-bit modes
	logic        baud_doubler;           // baud doubler
	logic        one_wire;       // single wire select
	logic        filter;         // multiprocessor filter
	logic        ren;            // receive enable

	logic        t1_half_q;      // divides timer 1 overflows by two
	logic        t1_tick;        // timer 1 derived oversample tick
	logic [1:0]  fix_cnt_q;      // fixed-rate prescaler
	logic        fix_tick;       // fixed-rate oversample tick
	logic        rx_tick;        // receiver oversample tick
	logic        tx_tick;        // transmitter oversample tick

	tx_state_t   tx_state_q;     // transmitter state
	logic [10:0] tx_sh_q;        // outgoing frame, lsb first
	logic [3:0]  tx_bit_q;       // bit index within frame
	logic [3:0]  tx_sub_q;       // oversample count within bit
	logic        tx_phase_q;     // shift clock phase in shift mode
	logic        tx_done_q;      // one-cycle transmit done event
	logic [3:0]  tx_total;       // frame length of current async mode
	logic        tx_start;       // data buffer written

	rx_state_t   rx_state_q;     // receiver state
	logic [8:0]  rx_sh_q;        // incoming bits, filled from top
	logic [3:0]  rx_bit_q;       // received data bit count
	logic [3:0]  rx_sub_q;       // oversample count within bit
	logic        rx_phase_q;     // shift clock phase when receiving
	logic [7:0]  rx_buf_q;       // received byte, read-only storage
	logic        rx_load_q;      // one-cycle receive done event
	logic        rx_ninth_q;     // ninth bit or stop to capture
	logic        rx_line;        // selected receive pin level
	logic        rx_prev_q;      // line level at the previous tick
	logic [3:0]  rx_count;       // data bits of current mode
	logic        accept;         // frame passes the filter

	// ---------------- bus slave ----------------

	// every access stalls one cycle, completing on the second edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (read | write) & ~ack_q;
		end
	end

	assign waitrequest = (read | write) & ~ack_q;
	assign wr_en       = write & ack_q;
	assign readdata    = readdata_q;

	// read mux; unmapped and write-only locations return zero
	always_comb begin
		rd_mux = 8'h00;
		case (address)
			idx_power:      rd_mux = power_q;
			idx_option:     rd_mux = option_q;
			idx_control:    rd_mux = control_q;
			idx_data:       rd_mux = rx_buf_q;
			idx_irq_status: rd_mux = {6'h00, irq_status_q};
			idx_irq_enable: rd_mux = {6'h00, irq_enable_q};
			idx_baud_src:   rd_mux = {6'h00, src_q};
			default:        rd_mux = 8'h00;
		endcase
	end

	// read data captured in the first cycle, stands at the completing edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			readdata_q <= 32'h00000000;
		end else if (read && !ack_q) begin
			readdata_q <= {24'h000000, rd_mux};
		end
	end

	// plain configuration registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			power_q      <= power_reset;
			option_q     <= option_reset;
			src_q        <= src_reset;
			irq_enable_q <= irq_reset;
		end else if (wr_en) begin
			case (address)
				idx_power:      power_q <= writedata[7:0] & power_rw_mask;
				idx_option:     option_q <= writedata[7:0];
				idx_baud_src:   src_q <= writedata[1:0];
				idx_irq_enable: irq_enable_q <= writedata[1:0];
				default:        ;
			endcase
		end
	end

	// serial_control; hardware sets win over a software write in the
	// same cycle so no done event is ever lost
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			control_q <= control_reset;
		end else begin
			if (wr_en && address == idx_control) begin
				control_q <= writedata[7:0];
			end
			if (rx_load_q) begin
				control_q[rx_ninth_bit_pos] <= rx_ninth_q;
				control_q[rx_done_flag_pos] <= 1'b1;
			end
			if (tx_done_q) begin
				control_q[tx_done_flag_pos] <= 1'b1;
			end
		end
	end

	// sticky interrupt events, cleared by writing ones; set wins
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			irq_status_q <= irq_reset;
			irq          <= 1'b0;
		end else begin
			if (wr_en && address == idx_irq_clear) begin
				irq_status_q <= irq_status_q & ~writedata[1:0];
			end
			if (tx_done_q) begin
				irq_status_q[irq_tx_pos] <= 1'b1;
			end
			if (rx_load_q) begin
				irq_status_q[irq_rx_pos] <= 1'b1;
			end
			irq <= |(irq_status_q & irq_enable_q);
		end
	end

	// ---------------- field decode ----------------

	assign mode     = {control_q[frame_mode_high_pos],
		control_q[frame_mode_low_pos]};
	assign nine     = mode[1];
	assign baud_doubler     = power_q[baud_doubler_pos];
	assign one_wire = option_q[single_wire_pos];
	// the filter has no meaning in shift mode and is ignored there
	assign filter   = control_q[multiproc_filter_pos];
	assign ren      = control_q[rx_enable_pos];
	assign tx_start = wr_en && address == idx_data;
	assign tx_total = nine ? async9_bits : async8_bits;
	assign rx_count = nine ? 4'h9 : 4'h8;
	// one-wire mode listens on the transmit pin
	assign rx_line  = one_wire ? txd_in : rxd_in;

	// ---------------- baud ticks ----------------

	// timer 1 overflows give a tick each, or every second one
	// when the doubler is clear; sixteen ticks make one bit
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			t1_half_q <= 1'b0;
		end else if (timer1_overflow) begin
			t1_half_q <= ~t1_half_q;
		end
	end

	assign t1_tick = timer1_overflow & (baud_doubler | t1_half_q);

	// free prescaler for the fixed nine-bit mode
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fix_cnt_q <= 2'h0;
		end else begin
			fix_cnt_q <= fix_cnt_q + 2'h1;
		end
	end

	// doubled: tick every 2 clocks (fsys/32), else every 4 (fsys/64)
	assign fix_tick = baud_doubler ? fix_cnt_q[0] : (fix_cnt_q == fixed_last);

	// timer 2 overflow is used directly, so a bit is 16 overflows
	assign rx_tick = (mode == mode_fixed9) ? fix_tick :
		(src_q[rx_baud_source_pos] ? timer2_overflow : t1_tick);
	assign tx_tick = (mode == mode_fixed9) ? fix_tick :
		(src_q[tx_baud_source_pos] ? timer2_overflow : t1_tick);

	// ---------------- transmitter ----------------

	// a write while busy is dropped rather than corrupting a frame
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_state_q <= tx_idle;
			tx_sh_q    <= 11'h7FF;
			tx_bit_q   <= 4'h0;
			tx_sub_q   <= 4'h0;
			tx_phase_q <= 1'b0;
			tx_done_q  <= 1'b0;
		end else begin
			tx_done_q <= 1'b0;
			case (tx_state_q)
				tx_idle: begin
					tx_bit_q   <= 4'h0;
					tx_sub_q   <= 4'h0;
					tx_phase_q <= 1'b0;
					if (tx_start && mode == mode_shift) begin
						tx_sh_q    <= {3'h7, writedata[7:0]};
						tx_state_q <= tx_shift;
					end else if (tx_start) begin
						// stop, ninth, data, start; 8-bit frames see
						// the stop bit in the ninth slot
						tx_sh_q <= {1'b1, nine ?
							control_q[tx_ninth_bit_pos] : 1'b1,
							writedata[7:0], 1'b0};
						tx_state_q <= tx_async;
					end
				end
				tx_async: begin
					if (tx_tick) begin
						tx_sub_q <= tx_sub_q + 4'h1;
						if (tx_sub_q == tick_last) begin
							tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
							tx_bit_q <= tx_bit_q + 4'h1;
							// entering the stop bit
							if (tx_bit_q == tx_total - 4'h2) begin
								tx_done_q <= 1'b1;
							end
							if (tx_bit_q == tx_total - 4'h1) begin
								tx_state_q <= tx_idle;
							end
						end
					end
				end
				tx_shift: begin
					// two clocks a bit: low phase, then high phase
					tx_phase_q <= ~tx_phase_q;
					if (tx_phase_q) begin
						tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == shift_bits - 4'h1) begin
							tx_done_q  <= 1'b1;
							tx_state_q <= tx_idle;
						end
					end
				end
				default: tx_state_q <= tx_idle;
			endcase
		end
	end

	// ---------------- receiver ----------------

	// line level at the last tick; resets to the idle level so that no
	// false start edge follows reset, and a low stop bit cannot restart
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_prev_q <= 1'b1;
		end else if (rx_tick) begin
			rx_prev_q <= rx_line;
		end
	end

	// the filter decision made at the stop-bit sample point
	always_comb begin
		accept = !control_q[rx_done_flag_pos];
		if (nine) begin
			accept = accept && (!filter || rx_sh_q[8]);
		end else begin
			accept = accept && (!filter || rx_line);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_state_q <= rx_idle;
			rx_sh_q    <= 9'h000;
			rx_bit_q   <= 4'h0;
			rx_sub_q   <= 4'h0;
			rx_phase_q <= 1'b0;
			rx_buf_q   <= 8'h00;
			rx_load_q  <= 1'b0;
			rx_ninth_q <= 1'b0;
		end else begin
			rx_load_q <= 1'b0;
			case (rx_state_q)
				rx_idle: begin
					rx_bit_q   <= 4'h0;
					rx_sub_q   <= 4'h0;
					rx_phase_q <= 1'b0;
					if (ren && mode == mode_shift &&
						!control_q[rx_done_flag_pos] &&
						tx_state_q == tx_idle) begin
						rx_state_q <= rx_shift;
					end else if (ren && mode != mode_shift &&
						rx_tick && rx_prev_q && !rx_line) begin
						rx_state_q <= rx_start;
					end
				end
				rx_start: begin
					if (!ren) begin
						rx_state_q <= rx_idle;
					end else if (rx_tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						// centre of start bit; a glitch returns to idle
						if (rx_sub_q == tick_centre - 4'h1) begin
							rx_sub_q   <= 4'h0;
							rx_state_q <= rx_line ? rx_idle : rx_data;
						end
					end
				end
				rx_data: begin
					if (!ren) begin
						rx_state_q <= rx_idle;
					end else if (rx_tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == tick_last) begin
							rx_sh_q  <= {rx_line, rx_sh_q[8:1]};
							rx_bit_q <= rx_bit_q + 4'h1;
							if (rx_bit_q == rx_count - 4'h1) begin
								rx_state_q <= rx_stop;
							end
						end
					end
				end
				rx_stop: begin
					if (!ren) begin
						rx_state_q <= rx_idle;
					end else if (rx_tick) begin
						rx_sub_q <= rx_sub_q + 4'h1;
						if (rx_sub_q == tick_last) begin
							rx_state_q <= rx_idle;
							if (accept) begin
								rx_buf_q   <= nine ? rx_sh_q[7:0] :
									rx_sh_q[8:1];
								rx_ninth_q <= nine ? rx_sh_q[8] :
									rx_line;
								rx_load_q  <= 1'b1;
							end
						end
					end
				end
				rx_shift: begin
					// sample on the rising half of our shift clock
					rx_phase_q <= ~rx_phase_q;
					if (rx_phase_q) begin
						rx_sh_q  <= {rxd_in, rx_sh_q[8:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == shift_bits - 4'h1) begin
							rx_buf_q   <= {rxd_in, rx_sh_q[8:2]};
							rx_ninth_q <= control_q[rx_ninth_bit_pos];
							rx_load_q  <= 1'b1;
							rx_state_q <= rx_idle;
						end
					end
				end
				default: rx_state_q <= rx_idle;
			endcase
		end
	end

	// ---------------- pins ----------------

	// pins are registered; in shift mode the transmit pin carries the
	// clock and the receive pin the data, so one-wire does not apply
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			txd_out <= 1'b1;
			txd_oe  <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end else if (mode == mode_shift) begin
			txd_out <= !((tx_state_q == tx_shift && !tx_phase_q) ||
				(rx_state_q == rx_shift && !rx_phase_q));
			txd_oe  <= 1'b1;
			rxd_out <= tx_sh_q[0];
			rxd_oe  <= tx_state_q == tx_shift;
		end else begin
			txd_out <= tx_sh_q[0];
			// one-wire: release the shared pin between frames
			txd_oe  <= !one_wire || tx_state_q == tx_async;
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end
	end

endmodule // serial_port

// ===== serial_port_checker.sv
// checker for the serial port: bus, pin and interrupt relations.
// assumes it is bound to serial_port and sees only its ports.
`timescale 1ns/1ps
module serial_port_checker (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic        rxd_oe,
	input wire logic        txd_out,
	input wire logic        txd_oe,
	input wire logic        irq
);
	import uart_pkg::*;
	logic [7:0] ctl_q; // snooped control, for the frame mode
	logic [7:0] opt_q; // snooped option, for one-wire select
	logic [1:0] en_q;  // snooped interrupt enables
	// follow completed writes; internal state is not visible here
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctl_q <= 8'h00;
			opt_q <= 8'h00;
			en_q  <= 2'h0;
		end else if (write && !waitrequest) begin
			if (address == idx_control) ctl_q <= writedata[7:0];
			if (address == idx_option) opt_q <= writedata[7:0];
			if (address == idx_irq_enable) en_q <= writedata[1:0];
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_BUS_WAIT:
		assert property ($rose(read || write) |-> waitrequest ##1 !waitrequest)
		else $error("bus answer not after one wait state");
	AST_RDATA_UPPER:
		assert property (readdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	// async bits last at least 16 clocks, so a fall stays low for 8
	AST_START_LOW:
		assert property (ctl_q[7:6] != mode_shift && txd_oe && $fell(txd_out)
			|-> !txd_out [*8])
		else $error("async bit shorter than expected");
	AST_SHIFT_CLOCK:
		assert property (ctl_q[7:6] == mode_shift && $fell(txd_out) |=> txd_out)
		else $error("shift clock low phase not one cycle");
	AST_RXD_OE:
		assert property (rxd_oe |-> ctl_q[7:6] == mode_shift)
		else $error("receive pin driven outside shift mode");
	AST_NORMAL_DRIVE:
		assert property ((!opt_q[7]) [*3] |-> txd_oe)
		else $error("transmit pin released in two-wire mode");
	AST_ONE_WIRE_RELEASE:
		assert property (opt_q[7] && $fell(txd_oe) |-> $past(txd_out))
		else $error("shared pin released while low");
	AST_IRQ_MASK:
		assert property (en_q == 2'h0 && $past(en_q) == 2'h0 |-> !irq)
		else $error("interrupt high while masked");
	cover property ($rose(irq));
	cover property ($rose(rxd_oe));
	cover property (opt_q[7] && $fell(txd_oe));
endmodule // serial_port_checker

bind serial_port serial_port_checker chk (
	.clock(clock), .nrst(nrst), .address(address),
	.read(read), .write(write), .writedata(writedata),
	.readdata(readdata), .waitrequest(waitrequest), .rxd_oe(rxd_oe),
	.txd_out(txd_out), .txd_oe(txd_oe), .irq(irq)
);

// ===== serial_port_with_one_wire_mode_test.sv
// self-checking bench for the serial port with one-wire mode.
// assumes serial_peer and the bound checker are compiled with it.
`timescale 1ns/1ps
module serial_port_with_one_wire_mode_test;
	import uart_pkg::*;
	logic        clock = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  address = 8'h00;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic        timer1_overflow = 1'b0;
	logic        timer2_overflow = 1'b0;
	logic        one_wire = 1'b0; // peer moved onto the shared pin
	logic [3:0]  tick = 4'h0;     // timer pulse pattern counter
	logic [31:0] readdata;
	logic        waitrequest, rxd_out, rxd_oe, txd_out, txd_oe, irq;
	logic        peer_out, tx_wire, rxd_in;
	logic [7:0]  q;               // last read data
	logic [7:0]  sh;              // shift-mode bits
	int          num_errors = 0;
	int          checks_done = 0;
	always #2 clock = ~clock;
	// timer 1 overflows every 3 clocks, timer 2 every 4
	always @(posedge clock) begin
		tick <= (tick == 4'hB) ? 4'h0 : tick + 4'h1;
		timer1_overflow <= (tick % 4'h3) == 4'h0;
		timer2_overflow <= tick[1:0] == 2'h0;
	end
	// pins with pull-ups; both parties may pull the shared pin low
	assign tx_wire = (txd_oe ? txd_out : 1'b1) & (one_wire ? peer_out : 1'b1);
	assign rxd_in = rxd_oe ? rxd_out : (one_wire ? 1'b1 : peer_out);
	serial_port DUT (
		.clock(clock), .nrst(nrst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .timer1_overflow(timer1_overflow),
		.timer2_overflow(timer2_overflow), .rxd_in(rxd_in),
		.rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_in(tx_wire),
		.txd_out(txd_out), .txd_oe(txd_oe), .irq(irq)
	);
	serial_peer peer (.clock(clock), .line_in(tx_wire), .line_out(peer_out));
	task automatic tally_and_finish();
		if (num_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		address <= a;
		write <= w;
		read <= !w;
		writedata <= {24'h0, d};
		// waitrequest is looked at on the rising edge, as the slave sees it
		do @(posedge clock); while (waitrequest !== 1'b0);
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input string what, input logic [7:0] a,
		input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(what, {24'h0, q}, {24'h0, e});
	endtask
	// irq is registered: let two edges land before looking
	task automatic irq_chk(input logic e);
		repeat (2) @(negedge clock);
		check("irq", {31'h0, irq}, {31'h0, e});
	endtask
	// send one byte, compare the captured frame and the done flag
	task automatic tx_chk(input logic [7:0] d, input logic nin, input int len,
		input logic [7:0] c);
		int s;
		s = peer.seen;
		peer.bit_len = len;
		wr(idx_data, d);
		while (peer.seen == s) @(posedge clock);
		check("tx frame", {22'h0, peer.got}, {22'h0, 1'b1, nin, d});
		// nine-bit frames outlast the capture by half a bit, and a
		// busy transmitter drops the next data write
		repeat (len) @(posedge clock);
		rd("tx done", idx_control, c | 8'h02);
		wr(idx_control, c);
	endtask
	// peer sends; compare control, then data when a frame was taken
	task automatic rx_chk(input logic [7:0] c, input logic [8:0] d,
		input int n, input logic stop, input logic [7:0] e);
		peer.send(d, n, stop);
		rd("rx control", idx_control, e);
		if (e[rx_done_flag_pos]) rd("rx data", idx_data, d[7:0]);
		wr(idx_control, c);
	endtask
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		rd("control", idx_control, control_reset);
		rd("option", idx_option, option_reset);
		rd("power", idx_power, power_reset);
		rd("unmapped", 8'h10, 8'h00);
		wr(idx_power, 8'hFF);
		rd("power", idx_power, 8'h8F);
		wr(idx_option, 8'h7E);
		rd("option", idx_option, 8'h7E);
		wr(idx_option, 8'h00);
		wr(idx_irq_clear, 8'h03);
		wr(idx_irq_status, 8'hFF);
		rd("status", idx_irq_status, 8'h00);
		wr(idx_irq_enable, 8'h01);
		// fixed nine-bit mode at both doubler settings and ninth values
		for (int s = 0; s < 2; s++) begin
			wr(idx_power, {s[0], 7'h0});
			wr(idx_control, 8'h80 | {4'h0, s[0], 3'h0});
			tx_chk(8'hA5 ^ {7'h0, s[0]}, s[0], s ? 32 : 64,
				8'h80 | {4'h0, s[0], 3'h0});
		end
		irq_chk(1'b1);
		wr(idx_irq_enable, 8'h00);
		irq_chk(1'b0);
		wr(idx_irq_enable, 8'h01);
		rd("status", idx_irq_status, 8'h01);
		wr(idx_irq_clear, 8'h01);
		irq_chk(1'b0);
		// eight-bit mode from timer 1, doubled, then timer 2
		wr(idx_power, 8'h00);
		wr(idx_control, 8'h40);
		tx_chk(8'h3C, 1'b1, 96, 8'h40);
		wr(idx_power, 8'h80);
		tx_chk(8'hC3, 1'b1, 48, 8'h40);
		wr(idx_baud_src, 8'h01);
		tx_chk(8'h5A, 1'b1, 64, 8'h40);
		// nine-bit variable mode, receive from timer 2 with the filter
		wr(idx_baud_src, 8'h02);
		peer.bit_len = 64;
		wr(idx_control, 8'hF0);
		rx_chk(8'hF0, 9'h0A5, 9, 1'b1, 8'hF0);
		rx_chk(8'hF0, 9'h1A5, 9, 1'b1, 8'hF5);
		wr(idx_control, 8'hE0);
		rx_chk(8'hE0, 9'h1A5, 9, 1'b1, 8'hE0);
		tx_chk(8'h11, 1'b0, 48, 8'hE0);
		rd("rx kept", idx_data, 8'hA5);
		// eight-bit receive from timer 1, stop bit good and bad
		wr(idx_baud_src, 8'h00);
		peer.bit_len = 48;
		wr(idx_control, 8'h50);
		rx_chk(8'h50, 9'h03C, 8, 1'b1, 8'h55);
		wr(idx_control, 8'h70);
		rx_chk(8'h70, 9'h0C3, 8, 1'b0, 8'h70);
		// one shared pin in both directions
		one_wire <= 1'b1;
		wr(idx_option, 8'h80);
		wr(idx_control, 8'h90);
		peer.bit_len = 32;
		rx_chk(8'h80, 9'h1C3, 9, 1'b1, 8'h95);
		tx_chk(8'h69, 1'b0, 32, 8'h80);
		// shift mode; filter kept clear here
		one_wire <= 1'b0;
		wr(idx_option, 8'h00);
		wr(idx_control, 8'h00);
		wr(idx_data, 8'h96);
		for (int i = 0; i < 8; i++) begin
			@(posedge txd_out);
			sh[i] = rxd_out;
		end
		check("shift out", {24'h0, sh}, 32'h96);
		rd("shift done", idx_control, 8'h02);
		// shift-mode receive: the peer holds the data pin low
		peer.line_out <= 1'b0;
		wr(idx_control, 8'h10);
		repeat (24) @(posedge clock);
		rd("shift rx", idx_control, 8'h11);
		rd("shift data", idx_data, 8'h00);
		peer.line_out <= 1'b1;
		tally_and_finish();
	end
	// watchdog: the whole run needs well under 20000 clocks
	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		tally_and_finish();
	end
endmodule // serial_port_with_one_wire_mode_test

// ===== uart_pkg.sv
// register map, field positions, reset values and baud constants of the
// serial port. assumes a single system clock and timer overflow pulses.
package uart_pkg;

	// register indices; the bus address is the index itself, with no scaling
	localparam logic [7:0] idx_power      = 8'h87; // power_and_baud_control
	localparam logic [7:0] idx_option     = 8'h94; // option_settings
	localparam logic [7:0] idx_control    = 8'h98; // serial_control
	localparam logic [7:0] idx_data       = 8'h99; // serial_data_buffer
	localparam logic [7:0] idx_irq_status = 8'hB0; // sticky events, read only
	localparam logic [7:0] idx_irq_enable = 8'hB1; // interrupt enables
	localparam logic [7:0] idx_irq_clear  = 8'hB2; // write one to clear
	localparam logic [7:0] idx_baud_src   = 8'hB3; // bit clock sources

	// field positions
	localparam int baud_doubler_pos     = 7;
	localparam int single_wire_pos      = 7;
	localparam int frame_mode_high_pos  = 7;
	localparam int frame_mode_low_pos   = 6;
	localparam int multiproc_filter_pos = 5;
	localparam int rx_enable_pos        = 4;
	localparam int tx_ninth_bit_pos     = 3;
	localparam int rx_ninth_bit_pos     = 2;
	localparam int tx_done_flag_pos     = 1;
	localparam int rx_done_flag_pos     = 0;
	localparam int rx_baud_source_pos   = 1;
	localparam int tx_baud_source_pos   = 0;
	localparam int irq_tx_pos           = 0;
	localparam int irq_rx_pos           = 1;

	// reset values
	localparam logic [7:0] power_reset   = 8'h00;
	localparam logic [7:0] option_reset  = 8'h00;
	localparam logic [7:0] control_reset = 8'h00;
	localparam logic [1:0] src_reset     = 2'h0;
	localparam logic [1:0] irq_reset     = 2'h0;
	localparam logic [7:0] power_rw_mask = 8'h8F; // bits 6..4 read zero

	// frame mode encodings
	localparam logic [1:0] mode_shift    = 2'h0;
	localparam logic [1:0] mode_async8   = 2'h1;
	localparam logic [1:0] mode_fixed9   = 2'h2;
	localparam logic [1:0] mode_var9     = 2'h3;

	// timing: oversample ticks per bit and centre sample point
	localparam logic [3:0] tick_last     = 4'hF; // 16 ticks per bit
	localparam logic [3:0] tick_centre   = 4'h7; // start bit checked here
	// fixed nine-bit mode, doubler clear: one tick every 4 clocks (fsys/64 per bit)
	localparam logic [1:0] fixed_last    = 2'h3;
	localparam logic [3:0] async8_bits   = 4'hA; // start, 8 data, stop
	localparam logic [3:0] async9_bits   = 4'hB; // start, 9 data, stop
	localparam logic [3:0] shift_bits    = 4'h8; // shift-register mode

	typedef enum logic [1:0] {tx_idle, tx_async, tx_shift} tx_state_t;
	typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_stop,
		rx_shift} rx_state_t;

endpackage
